// >>> logic/rpd_ctrl.sv
/*
  Rank power-down controller: CKE, chip-select and I/O enables per rank,
  idle power-down, refresh wake-up, conditional self-refresh, AXI4-Lite regs.
  Assumes all non-bus inputs come from logic on CLOCK; refresh request is a
  level held by the scheduler until its refresh is done.
*/
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
module rpd_ctrl
  import rpd_pkg::*;
#(
  parameter int INIT_CYC = INIT_LOW_CYC
)(
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  input  wire logic        CE,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output var  logic        S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output var  logic        S_AXI_WREADY,
  output var  logic [1:0]  S_AXI_BRESP,
  output var  logic        S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output var  logic        S_AXI_ARREADY,
  output var  logic [31:0] S_AXI_RDATA,
  output var  logic [1:0]  S_AXI_RRESP,
  output var  logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic [3:0]  RANK_ARRIVE,
  input  wire logic [3:0]  RANK_QUEUED,
  input  wire logic [3:0]  PAGES_OPEN,
  input  wire logic        REFRESH_REQ,
  input  wire logic [2:0]  PKG_CSTATE,
  input  wire logic        S3_REQ,
  input  wire logic        IGFX_USED,
  input  wire logic        GFX_IDLE,
  input  wire logic        DISPLAY_PEND,
  input  wire logic        MEM_REQ_PEND,
  input  wire logic [3:0]  GFX_RANK,
  input  wire logic        FLUSH_DONE,
  input  wire logic        PWR_THROTTLE,
  output var  logic [3:0]  CKE,
  output var  logic [3:0]  CKE_OE,
  output var  logic [3:0]  CS_OE,
  output var  logic [3:0]  AUX_OE,
  output var  logic [3:0]  RX_EN,
  output var  logic        IO_DLL_EN,
  output var  logic        DRAM_DLL_OFF,
  output var  logic [3:0]  PRECHARGE_REQ,
  output var  logic [3:0]  CMD_BLOCK,
  output var  logic        REFRESH_GO,
  output var  logic        FLUSH_REQ
);

  // ****************************************
  // Declarations
  // ****************************************
  rpd_cfg_t    cfg;                   // Mode and idle threshold
  rpd_ctrl_t   ctrl;                  // Release and population
  rpd_stat_t   stat;                  // Readback view
  rpd_pdm_t    mode_sel;              // Decoded mode
  logic [11:0] thresh;                // Effective idle threshold
  logic [15:0] init_cnt;              // Power-up low timer
  logic        init_done;
  logic [15:0] thr_cnt;               // Throttled clocks seen
  logic        sr_cond;               // Self-refresh wanted
  logic        sr_go;                 // Flushed, self-refresh granted
  logic        deep;                  // Package C3 or deeper
  logic        ref_q;                 // Refresh request, last cycle
  logic [3:0]  drive;                 // Rank pins in use
  logic [3:0]  rank_cke, pre, blk, pd, sr;
  logic        aw_hold, w_hold;       // Write halves captured
  logic [7:0]  waddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        do_wr;
  logic [31:0] rd_mux;
  logic        rd_ok;
  logic [31:0] merged;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] rpd_merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // AXI4-Lite write
  // ****************************************
  assign do_wr = aw_hold && w_hold && !S_AXI_BVALID;

  // Address and data taken in either order
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      waddr         <= 8'h00;
      wdata         <= 32'h0;
      wstrb         <= 4'h0;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold       <= 1'b1;
        waddr         <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold       <= 1'b1;
        wdata        <= S_AXI_WDATA;
        wstrb        <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_wr) begin
        // Unmapped write is dropped with an error
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (waddr == ADDR_CFG || waddr == ADDR_CTRL) ? RESP_OKAY : RESP_SLVER;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  assign merged = rpd_merge((waddr == ADDR_CFG) ? {16'h0, cfg} : {23'h0, ctrl}, wdata, wstrb);

  // Register storage
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      cfg  <= rpd_cfg_t'(CFG_RST);
      ctrl <= rpd_ctrl_t'(CTRL_RST);
    end else if (CE && do_wr) begin
      if (waddr == ADDR_CFG) begin
        cfg <= rpd_cfg_t'(merged[15:0]);
      end
      if (waddr == ADDR_CTRL) begin
        ctrl <= rpd_ctrl_t'(merged[8:0] & CTRL_WMASK);
      end
    end
  end

  // ****************************************
  // AXI4-Lite read
  // ****************************************
  assign stat = '{thr_cnt: thr_cnt, rsvd: 6'h00, init_done: init_done, flush_pend: FLUSH_REQ, sr: sr, pd: pd};

  // Read decode, unmapped reads zero
  always_comb begin
    rd_ok = 1'b1;
    case (S_AXI_ARADDR)
      ADDR_CFG:  rd_mux = {16'h0, cfg};
      ADDR_CTRL: rd_mux = {23'h0, ctrl};
      ADDR_STAT: rd_mux = stat;
      default: begin
        rd_mux = 32'h0;
        rd_ok  = 1'b0;
      end
    endcase
  end

  // Data captured at address handshake
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RDATA   <= rd_mux;
        S_AXI_RRESP   <= rd_ok ? RESP_OKAY : RESP_SLVER;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID  <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // ****************************************
  // Policy
  // ****************************************
  // unknown codes disable power-down
  always_comb begin
    case (cfg.mode)
      MODE_APD: mode_sel = PDM_APD;
      MODE_PPD: mode_sel = PDM_PPD;
      default:  mode_sel = PDM_NONE;
    endcase
  end

  assign thresh = PWR_THROTTLE ? {1'b0, cfg.idle[11:1]} : cfg.idle;

  assign deep = PKG_CSTATE == CST_C3 || PKG_CSTATE == CST_C6 || PKG_CSTATE == CST_C7;
  assign sr_cond = S3_REQ || (deep && (IGFX_USED ? (GFX_IDLE && !DISPLAY_PEND) : !MEM_REQ_PEND));

  assign drive = ~({4{ctrl.tri_en}} & (ctrl.absent | {4{ctrl.chan_off}}));

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      sr_go     <= 1'b0;
      FLUSH_REQ <= 1'b0;
    end else if (CE) begin
      if (!sr_cond) begin
        sr_go     <= 1'b0;
        FLUSH_REQ <= 1'b0;
      end else if (FLUSH_REQ && FLUSH_DONE) begin
        sr_go     <= 1'b1;
        FLUSH_REQ <= 1'b0;
      end else if (!sr_go) begin
        FLUSH_REQ <= 1'b1;
      end
    end
  end

  // Power-up timer and throttle monitor
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      init_cnt  <= 16'h0000;
      init_done <= 1'b0;
      thr_cnt   <= 16'h0000;
      ref_q     <= 1'b0;
    end else if (CE) begin
      // CKE low past the least time
      if (!init_done) begin
        init_cnt  <= init_cnt + 16'h0001;
        init_done <= init_cnt == 16'(INIT_CYC - 1);
      end
      if (PWR_THROTTLE && thr_cnt != 16'hffff) begin
        thr_cnt <= thr_cnt + 16'h0001;
      end
      ref_q <= REFRESH_REQ;
    end
  end

  // ****************************************
  // Ranks
  // ****************************************
  // one engine per CKE
  for (genvar i = 0; i < 4; i++) begin : g_rank
    rpd_rank u_rank (
      .clk        (CLOCK),
      .rst_n      (NRST),
      .ce         (CE),
      .mode       (mode_sel),
      .thresh     (thresh),
      .arrive     (RANK_ARRIVE[i]),
      .queued     (RANK_QUEUED[i]),
      .pages_open (PAGES_OPEN[i]),
      .wake       (REFRESH_REQ),
      .ref_done   (ref_q && !REFRESH_REQ),
      .sr_req     (sr_go && !GFX_RANK[i]),
      .cke        (rank_cke[i]),
      .pre_req    (pre[i]),
      .cmd_block  (blk[i]),
      .in_pd      (pd[i]),
      .in_sr      (sr[i])
    );
  end

  // ****************************************
  // Pin registers
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      CKE           <= 4'h0;
      CKE_OE        <= 4'hf;
      CS_OE         <= 4'hf;
      AUX_OE        <= 4'hf;
      RX_EN         <= 4'hf;
      IO_DLL_EN     <= 1'b1;
      DRAM_DLL_OFF  <= 1'b0;
      PRECHARGE_REQ <= 4'h0;
      CMD_BLOCK     <= 4'h0;
      REFRESH_GO    <= 1'b0;
    end else if (CE) begin
      CKE    <= drive & rank_cke & {4{ctrl.cke_go && init_done}};
      CKE_OE <= drive;
      CS_OE  <= drive;
      AUX_OE <= drive;
      RX_EN     <= drive;
      IO_DLL_EN <= |drive;
      // DRAM DLL off in this mode
      DRAM_DLL_OFF  <= mode_sel == PDM_PPD;
      PRECHARGE_REQ <= pre;
      CMD_BLOCK     <= blk;
      REFRESH_GO <= REFRESH_REQ && (&((rank_cke & ~blk) | sr));
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST || !CE);

  AST_NO_DRIVE: assert property (ctrl.tri_en && ctrl.absent[0] |=> !CKE_OE[0] && !CS_OE[0] && !CKE[0])
    else $error("Absent rank still driven");
  AST_POPULATED: assert property (!ctrl.tri_en && !ctrl.chan_off |=> CKE_OE == 4'hf && CS_OE == 4'hf)
    else $error("Rank undriven before tri-stating enabled");
  AST_CKE_HELD: assert property (!(ctrl.cke_go && init_done) |=> CKE == 4'h0)
    else $error("CKE rose before release");
  AST_SHALLOW: assert property (PKG_CSTATE <= CST_C1E && !S3_REQ |=> !sr_go)
    else $error("Self-refresh granted in shallow state");
  AST_IGFX_BUSY: assert property (deep && IGFX_USED && !GFX_IDLE && !S3_REQ |=> !sr_go)
    else $error("Self-refresh while graphics busy");
  AST_EXT_BUSY: assert property (deep && !IGFX_USED && MEM_REQ_PEND && !S3_REQ |=> !sr_go)
    else $error("Self-refresh with memory requests pending");
  AST_FLUSH_FIRST: assert property ($rose(sr_go) |-> $past(FLUSH_REQ) && $past(FLUSH_DONE))
    else $error("Self-refresh granted without flush");
  AST_REFRESH_UP: assert property (REFRESH_GO |-> $past(REFRESH_REQ) && (&$past((rank_cke & ~blk) | sr)))
    else $error("Refresh released with a rank down");
  AST_NONE_MODE: assert property (mode_sel == PDM_NONE && !sr_go |=> (pd & ~$past(pd)) == 4'h0)
    else $error("Power-down entered in no power-down mode");

  COV_PD: cover property ($rose(|pd));
  COV_SR: cover property ($rose(sr_go) ##[1:20] (|sr));
  COV_REFRESH: cover property ($rose(REFRESH_GO));

endmodule

// >>> logic/rpd_pkg.sv
/*
  Shared constants and types for the rank power-down controller.
  Assumes one 50 MHz DRAM-side clock and a 32-bit AXI4-Lite register bus.
*/
package rpd_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int         CLK_PERIOD_NS = 20;                        // 50 MHz
  localparam int         INIT_LOW_US   = 200;                       // Least CKE-low time at power-up
  localparam int         INIT_LOW_CYC  = (INIT_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] TXP_CYC       = 5'h03;                     // Power-down exit delay
  localparam logic [4:0] TXPDLL_CYC    = 5'h14;                     // DLL relock, worst DDR type
  localparam logic [4:0] EXIT_APD_CYC  = TXP_CYC;
  localparam logic [4:0] EXIT_PPD_CYC  = TXP_CYC + TXPDLL_CYC;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CFG   = 8'h00;                        // rank_power_down_config
  localparam logic [7:0] ADDR_CTRL  = 8'h04;                        // Release and population
  localparam logic [7:0] ADDR_STAT  = 8'h08;                        // Rank state, throttle count
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVER = 2'h2;

  // Config word: mode in 15:12, idle threshold in 11:0
  typedef struct packed {
    logic [3:0]  mode;
    logic [11:0] idle;
  } rpd_cfg_t;
  localparam logic [15:0] CFG_RST = 16'h6080;

  // Control word
  typedef struct packed {
    logic       chan_off;                                           // Whole channel unused
    logic [3:0] absent;                                             // Ranks found absent
    logic [1:0] rsvd;
    logic       tri_en;                                             // Allow tri-stating absent ranks
    logic       cke_go;                                             // Release CKE after init
  } rpd_ctrl_t;
  localparam logic [8:0] CTRL_RST   = 9'h000;
  localparam logic [8:0] CTRL_WMASK = 9'h1f3;

  // Status word
  typedef struct packed {
    logic [15:0] thr_cnt;
    logic [5:0]  rsvd;
    logic        init_done;
    logic        flush_pend;
    logic [3:0]  sr;
    logic [3:0]  pd;
  } rpd_stat_t;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [3:0] MODE_NONE = 4'h0;
  localparam logic [3:0] MODE_APD  = 4'h2;
  localparam logic [3:0] MODE_PPD  = 4'h6;
  typedef enum logic [1:0] {PDM_NONE, PDM_APD, PDM_PPD} rpd_pdm_t;

  localparam logic [2:0] CST_C0  = 3'h0;
  localparam logic [2:0] CST_C1  = 3'h1;
  localparam logic [2:0] CST_C1E = 3'h2;
  localparam logic [2:0] CST_C3  = 3'h3;
  localparam logic [2:0] CST_C6  = 3'h4;
  localparam logic [2:0] CST_C7  = 3'h5;

endpackage

// >>> logic/rpd_rank.sv
/*
  One rank's idle counter and CKE power state machine.
  Assumes the parent keeps sr_req low until pending cycles are flushed.
*/
`timescale 1ns/100ps
module rpd_rank
  import rpd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire rpd_pdm_t    mode,
  input  wire logic [11:0] thresh,
  input  wire logic        arrive,
  input  wire logic        queued,
  input  wire logic        pages_open,
  input  wire logic        wake,
  input  wire logic        ref_done,
  input  wire logic        sr_req,
  output var  logic        cke,
  output var  logic        pre_req,
  output var  logic        cmd_block,
  output var  logic        in_pd,
  output var  logic        in_sr
);

  typedef enum {ST_ACT, ST_CLOSE, ST_PD, ST_EXIT, ST_SR} rpd_rst_t;

  rpd_rst_t    state;                 // Power state
  logic [11:0] idle_cnt;              // Clocks since last arrival or queued request
  logic [4:0]  exit_cnt;              // Exit delay left
  logic        dll_exit;              // Exit needs DLL relock
  logic [4:0]  blk_len;               // Checker only: exit length
  logic        expired;
  logic        dyn;

  assign dyn     = mode != PDM_NONE;
  assign expired = (idle_cnt >= thresh) && !queued && !arrive;

  // ****************************************
  // Idle counter
  // ****************************************
  // restart on arrival
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_cnt <= 12'h000;
    end else if (ce) begin
      if (arrive || queued) begin
        idle_cnt <= 12'h000;
      end else if (idle_cnt != 12'hfff) begin
        // Saturate so a long idle never wraps
        idle_cnt <= idle_cnt + 12'h001;
      end
    end
  end

  // ****************************************
  // Power state machine
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= ST_ACT;
      exit_cnt <= 5'h00;
      dll_exit <= 1'b0;
    end else if (ce) begin
      case (state)
        // Self-refresh first, else idle power-down
        ST_ACT: begin
          if (sr_req && !queued) begin
            state <= ST_SR;
          end else if (dyn && !wake && (expired || (ref_done && !queued && !arrive))) begin
            state    <= (mode == PDM_PPD && pages_open) ? ST_CLOSE : ST_PD;
            dll_exit <= mode == PDM_PPD;
          end
        end
        // Waiting for precharge to finish
        ST_CLOSE: begin
          if (arrive || wake || sr_req || !dyn) begin
            state <= ST_ACT;
          end else if (!pages_open) begin
            state <= ST_PD;
          end
        end
        ST_PD: begin
          if (arrive || queued || wake || sr_req || !dyn) begin
            state <= ST_EXIT;
            exit_cnt <= dll_exit ? EXIT_PPD_CYC : EXIT_APD_CYC;
          end
        end
        // Self-refresh leaves with DLL relock
        ST_SR: begin
          if (!sr_req) begin
            state    <= ST_EXIT;
            exit_cnt <= EXIT_PPD_CYC;
            dll_exit <= 1'b1;
          end
        end
        // Commands held off until count ends
        ST_EXIT: begin
          if (exit_cnt == 5'h01) begin
            state <= ST_ACT;
          end else begin
            exit_cnt <= exit_cnt - 5'h01;
          end
        end
        default: begin
          state <= ST_ACT;
        end
      endcase
    end
  end

  assign cke       = (state == ST_ACT) || (state == ST_CLOSE) || (state == ST_EXIT);
  assign pre_req   = state == ST_CLOSE;
  assign cmd_block = state == ST_EXIT;
  assign in_pd     = state == ST_PD;
  assign in_sr     = state == ST_SR;

  // ****************************************
  // Checks
  // ****************************************
  // Length of the current exit window
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      blk_len <= 5'h00;
    end else if (ce) begin
      blk_len <= (state == ST_EXIT) ? blk_len + 5'h01 : 5'h00;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);

  AST_PPD_EXIT: assert property ($fell(cmd_block) && dll_exit |-> blk_len == EXIT_PPD_CYC)
    else $error("DLL-off exit window has wrong length");
  AST_APD_EXIT: assert property ($fell(cmd_block) && !dll_exit |-> blk_len == EXIT_APD_CYC)
    else $error("Active power-down exit window has wrong length");
  AST_IDLE_ENTRY: assert property ($rose(in_pd) && $past(state) == ST_ACT && !$past(ref_done)
    |-> $past(idle_cnt) >= $past(thresh))
    else $error("Rank powered down before idle threshold");
  AST_PAGES_CLOSED: assert property ($rose(in_pd) && $past(mode) == PDM_PPD |-> !$past(pages_open))
    else $error("Precharge power-down entered with open pages");
  AST_ARRIVE_RESET: assert property (arrive |=> idle_cnt == 12'h000)
    else $error("Idle counter not restarted by arrival");

  COV_PD_EXIT: cover property (in_pd ##1 cmd_block);

endmodule

// >>> dv/rpd_sdram_model.sv
/*
  SDRAM rank stand-in: holds one open-page flag per rank.
  Assumes CLOCK, NRST and open requests from the bench, precharge requests from the controller.
*/
`timescale 1ns/100ps
module rpd_sdram_model (
  input  wire logic       CLOCK,
  input  wire logic       NRST,
  input  wire logic [3:0] OPEN_REQ,
  input  wire logic [3:0] PRECHARGE_REQ,
  output var  logic [3:0] PAGES_OPEN
);
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      PAGES_OPEN <= 4'h0;
    end else begin
      PAGES_OPEN <= (PAGES_OPEN | OPEN_REQ) & ~PRECHARGE_REQ;
    end
  end
endmodule

// >>> dv/rpd_ctrl_tb.sv
/*
  Bench for rpd_ctrl: AXI4-Lite tasks, rank traffic, sleep policy table.
  Assumes INIT_CYC of 20 and the SDRAM stand-in for page state.
*/
`timescale 1ns/100ps
module rpd_ctrl_tb
  import rpd_pkg::*;
;
  logic        clk = 0, nrst = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic        rref = 0, s3 = 0, fld = 0, igfx = 0, gi = 0, mrq = 0, dp = 0, pt = 0;
  logic        bv, rv, awr, wrd, ard, rgo, freq, dlo, iodll;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat;
  logic [3:0]  arr = 0, opn = 0, gfx = 4'h1;
  logic [3:0]  cke, ckeoe, csoe, auxoe, rxen, pre, blk, pages;
  logic [2:0]  cst = 0;
  logic [1:0]  br, rr;
  int          num_errors = 0, tests_run = 0, n;
  logic [15:0] md [4] = '{16'h2002, 16'h6002, 16'h0002, 16'hf002};
  int          bl [4] = '{3, 23, 0, 0};
  // Policy rows: cstate, s3, igfx, gfx idle, mem req, display pend, flush expected
  logic [8:0]  tb [7] = '{9'h048, 9'h0cc, 9'h0c9, 9'h110, 9'h159, 9'h029, 9'h15a};

  rpd_ctrl #(.INIT_CYC(20)) DUT (.CLOCK(clk), .NRST(nrst), .CE(1'b1), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ard), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry), .RANK_ARRIVE(arr), .RANK_QUEUED(4'h0), .PAGES_OPEN(pages), .REFRESH_REQ(rref),
    .PKG_CSTATE(cst), .S3_REQ(s3), .IGFX_USED(igfx), .GFX_IDLE(gi), .DISPLAY_PEND(dp),
    .MEM_REQ_PEND(mrq), .GFX_RANK(gfx), .FLUSH_DONE(fld), .PWR_THROTTLE(pt), .CKE(cke),
    .CKE_OE(ckeoe), .CS_OE(csoe), .AUX_OE(auxoe), .RX_EN(rxen), .IO_DLL_EN(iodll), .DRAM_DLL_OFF(dlo),
    .PRECHARGE_REQ(pre), .CMD_BLOCK(blk), .REFRESH_GO(rgo), .FLUSH_REQ(freq));
  rpd_sdram_model MDL (.CLOCK(clk), .NRST(nrst), .OPEN_REQ(opn), .PRECHARGE_REQ(pre), .PAGES_OPEN(pages));

  // 50 MHz clock
  initial forever #10 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Reads before the edge's updates land, so values are the sampled ones
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
    // Ready stays high after the answer, so back-to-back calls never drive it twice in one step
    forever begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wrd) wv <= 0;
      if (bv) begin
        chk("bresp", er, br);
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    ara <= a; arv <= 1; rry <= 1;
    forever begin
      @(posedge clk);
      if (arv && ard) arv <= 0;
      if (rv) begin
        chk("rdata", ed, rdat);
        chk("rresp", er, rr);
        break;
      end
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    rd(ADDR_CFG, 32'h6080, RESP_OKAY);
    rd(ADDR_CTRL, 32'h0, RESP_OKAY);
    rd(8'h0c, 32'h0, RESP_SLVER);
    wr(ADDR_STAT, 32'h0, RESP_SLVER);
    repeat (30) @(posedge clk);
    chk("cke_init", 4'h0, cke);
    chk("ckeoe_rst", 4'hf, ckeoe);
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    repeat (5) @(posedge clk);
    chk("cke_go", 4'hf, cke);
    wr(ADDR_CTRL, 32'h83, RESP_OKAY);
    @(posedge clk);
    chk("csoe", 4'h7, csoe);
    chk("ckeoe", 4'h7, ckeoe);
    chk("auxoe", 4'h7, auxoe);
    chk("rxen", 4'h7, rxen);
    rd(ADDR_CTRL, 32'h83, RESP_OKAY);
    wr(ADDR_CTRL, 32'h103, RESP_OKAY);
    @(posedge clk);
    chk("iodll", 0, iodll);
    chk("ckeoe_off", 4'h0, ckeoe);
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CFG, {16'h0, md[i]}, RESP_OKAY);
      arr <= 4'h1; opn <= 4'h1;
      @(posedge clk);
      arr <= 4'h0; opn <= 4'h0;
      repeat (40) @(posedge clk);
      chk("cke0", i > 1, cke[0]);
      chk("page0", i != 1, pages[0]);
      chk("dll_off", i == 1, dlo);
      arr <= 4'h1;
      @(posedge clk);
      arr <= 4'h0; n = 0;
      repeat (40) begin @(posedge clk); if (blk[0] === 1'b1) n++; end
      chk("block0", bl[i], n);
    end
    $display("test modes done");
    wr(ADDR_CFG, 32'h2002, RESP_OKAY);
    repeat (40) @(posedge clk);
    rref <= 1;
    repeat (30) @(posedge clk);
    chk("cke_ref", 4'hf, cke);
    chk("ref_go", 1, rgo);
    rref <= 0;
    repeat (10) @(posedge clk);
    chk("cke_after_ref", 4'h0, cke);
    wr(ADDR_CFG, 32'h0002, RESP_OKAY);
    for (int i = 0; i < 7; i++) begin
      arr <= 4'hf;
      @(posedge clk);
      arr <= 0;
      {cst, s3, igfx, gi, mrq, dp} <= tb[i][8:1];
      repeat (40) @(posedge clk);
      chk("flush", tb[i][0], freq);
      fld <= 1;
      repeat (4) @(posedge clk);
      chk("cke_sr", tb[i][0] ? 4'h1 : 4'hf, cke);
      {cst, s3, igfx, gi, mrq, dp, fld} <= 11'h000;
    end
    $display("test self refresh done");
    // Five throttled clocks, then status: count 5, init done, nothing asleep
    pt <= 1;
    repeat (5) @(posedge clk);
    pt <= 0;
    rd(ADDR_STAT, 32'h00050200, RESP_OKAY);
    $display("test throttle done");
    tally_and_finish();
  end
endmodule
